// [design/sfs_pkg.sv]
package sfs_pkg;
  // ----------------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------------
  localparam int ROW_INSNS      = 64;    // instructions per row
  localparam int ROW_BYTES      = 192;   // bytes per row
  localparam int PAGE_ROWS      = 8;     // rows per erase page
  localparam int PAGE_INSNS     = 512;   // instructions per erase page
  localparam int PAGE_BYTES     = 1536;  // page alignment in bytes
  localparam int INSN_BYTES     = 3;     // bytes per instruction
  localparam int ADDR_W         = 24;    // program byte address width
  localparam int INSN_W         = 24;    // instruction width
  localparam int BUF_IDX_W      = 6;     // holding buffer index width
  localparam int LOW_W          = 16;    // low word width
  localparam int HIGH_W         = 8;     // high byte width

  // ----------------------------------------------------------------------
  // unlock keys and control register fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int CTRL_GO_BIT    = 15;    // go / busy bit
  localparam int CTRL_OP_LSB    = 0;     // operation select field
  localparam int CTRL_OP_W      = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // operation select codes
  typedef enum logic [1:0] {
    SFS_OP_NONE  = 2'h0,
    SFS_OP_WORD  = 2'h1,
    SFS_OP_ROW   = 2'h2,
    SFS_OP_ERASE = 2'h3
  } sfs_op_t;

  // ----------------------------------------------------------------------
  // timing from the fast rc oscillator
  // ----------------------------------------------------------------------
  localparam int ROW_OSC_CYCLES   = 11064; // row write length in osc cycles
  localparam int WORD_OSC_CYCLES  = 1000;  // word write length (plain)
  localparam int ERASE_OSC_CYCLES = 20000; // page erase length (plain)
  localparam int OSC_CNT_W        = 16;
  localparam int TUNE_W           = 6;     // osc tune field width
  localparam int TABLE_WR_CYCLES  = 2;     // cycles per table write
endpackage

// [design/sfs_if.sv]
`timescale 1ns/1ns
`default_nettype none
// core-to-sequencer connection
interface sfs_if;
  import sfs_pkg::*;
  logic                  tbl_wr;     // table write strobe
  logic                  tbl_hi;     // 1: table_write_high, 0: low
  logic [ADDR_W-1:0]     tbl_addr;   // program byte address
  logic [LOW_W-1:0]      tbl_data;   // write data
  logic                  key_wr;     // flash_unlock_key write strobe
  logic [7:0]            key_data;
  logic                  ctrl_wr;    // flash_op_control write strobe
  logic [15:0]           ctrl_data;
  logic [15:0]           ctrl_rd;    // flash_op_control readback
  logic                  stall;      // core stall
  logic                  tbl_done;   // table write completed

  modport dev  (input  tbl_wr, tbl_hi, tbl_addr, tbl_data, key_wr,
                       key_data, ctrl_wr, ctrl_data,
                output ctrl_rd, stall, tbl_done);
  modport core (output tbl_wr, tbl_hi, tbl_addr, tbl_data, key_wr,
                       key_data, ctrl_wr, ctrl_data,
                input  ctrl_rd, stall, tbl_done);
endinterface
`default_nettype wire

// [design/sfs_core_end.sv]
`timescale 1ns/1ns
`default_nettype none
// core side: runs one program/erase job from a simple user request
module sfs_core_end
  import sfs_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  req_i,       // start a job
  input  wire logic [1:0]            req_op_i,    // sfs_op_t code
  input  wire logic [ADDR_W-1:0]     req_addr_i,  // target byte address
  input  wire logic [INSN_W-1:0]     req_data_i,  // fill pattern
  output logic                       busy_o,
  output logic                       done_o,
  sfs_if.core                        bus
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SC_IDLE = 3'h0, SC_FILL = 3'h1, SC_KEY1 = 3'h3, SC_KEY2 = 3'h2,
    SC_GO = 3'h6, SC_WAIT = 3'h7, SC_POLL = 3'h5
  } sfs_cst_t;

  typedef struct packed {
    sfs_cst_t            st;
    logic [1:0]          op;
    logic [ADDR_W-1:0]   addr;
    logic [INSN_W-1:0]   data;
    logic [BUF_IDX_W:0]  idx;    // half-word count, low then high
    logic                tbl_wait; // a table write awaits its done
    logic                tbl_wr;
    logic                tbl_hi;
    logic                key_wr;
    logic [7:0]          key_data;
    logic                ctrl_wr;
    logic                busy;
    logic                done;
  } sfs_cs_t;

  sfs_cs_t s_ff, nxt_s;

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  // pointer, buffer load, then control bits
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.tbl_wr   = 1'b0;
    nxt_s.key_wr   = 1'b0;
    nxt_s.ctrl_wr  = 1'b0;
    nxt_s.done     = 1'b0;
    unique case (s_ff.st)
      SC_IDLE: begin
        if (req_i) begin
          nxt_s.op       = req_op_i;
          // a row job starts at its row base so every load stays in it
          nxt_s.addr     = (req_op_i == SFS_OP_ROW) ?
                           req_addr_i - (req_addr_i % ADDR_W'(ROW_BYTES))
                           : req_addr_i;
          nxt_s.data     = req_data_i;
          nxt_s.idx      = '0;
          nxt_s.tbl_wait = 1'b0;
          nxt_s.busy     = 1'b1;
          // erase loads one pair too: that table write names the page
          nxt_s.st       = SC_FILL;
        end
      end
      SC_FILL: begin
        // one table write at a time; a repeat before its done would
        // load the same slot twice and break the ascending fill
        if (!s_ff.tbl_wait && !bus.stall) begin
          nxt_s.tbl_wr   = 1'b1;
          nxt_s.tbl_hi   = s_ff.idx[0];
          nxt_s.tbl_wait = 1'b1;
        end
        if (bus.tbl_done) begin
          nxt_s.tbl_wait = 1'b0;
          nxt_s.idx      = s_ff.idx + 1'b1;
          if (s_ff.idx[0])
            nxt_s.addr = s_ff.addr + ADDR_W'(INSN_BYTES);
          // word and erase need one pair, row 64 pairs
          if ((s_ff.op != SFS_OP_ROW && s_ff.idx[0]) ||
              s_ff.idx == 7'h7f)
            nxt_s.st = SC_KEY1;
        end
      end
      SC_KEY1: begin
        nxt_s.key_wr   = 1'b1;
        nxt_s.key_data = KEY_FIRST;
        nxt_s.st       = SC_KEY2;
      end
      SC_KEY2: begin
        nxt_s.key_wr   = 1'b1;
        nxt_s.key_data = KEY_SECOND;
        nxt_s.st       = SC_GO;
      end
      SC_GO: begin
        nxt_s.ctrl_wr = 1'b1;
        nxt_s.st      = SC_WAIT;
      end
      SC_WAIT: nxt_s.st = SC_POLL;
      SC_POLL: begin
        // one job per row; stall ends with the go bit
        if (!bus.stall && !bus.ctrl_rd[CTRL_GO_BIT]) begin
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st   = SC_IDLE;
        end
      end
      default: nxt_s.st = SC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------------
  // drives
  // ----------------------------------------------------------------------
  assign bus.tbl_wr    = s_ff.tbl_wr;
  assign bus.tbl_hi    = s_ff.tbl_hi;
  assign bus.tbl_addr  = s_ff.addr;
  assign bus.tbl_data  = s_ff.tbl_hi ? {8'h00, s_ff.data[INSN_W-1:LOW_W]}
                                     : s_ff.data[LOW_W-1:0];
  assign bus.key_wr    = s_ff.key_wr;
  assign bus.key_data  = s_ff.key_data;
  assign bus.ctrl_wr   = s_ff.ctrl_wr;
  assign bus.ctrl_data = {1'b1, 13'h0000, s_ff.op};
  assign busy_o        = s_ff.busy;
  assign done_o        = s_ff.done;
endmodule
`default_nettype wire

// [design/sfs_dev_end.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------------
// Summary of operation
// - rows of 64 instructions, 192 bytes
// - erase clears one eight-row page
// - program a whole row or one word
// - page/row aligned; low address bits ignored
// - holding buffer stores 64 instructions
// - core fills buffer in ascending order
// - loaded words stay in one row
// - 64 low plus 64 high table writes
// - table write updates buffer in two cycles
// - each row needs its own cycle
// - core stalled while operation runs
// - timing counted in fast rc oscillator cycles
// - go bit starts, hardware clears at end
// - pointer, table writes, then control bits
// - full unlock sequence every operation
// - keys 0x55 then 0xaa consecutively
// - control selects erase, program kind, start
// ------------------------------------------------------------------------
module sfs_dev_end
  import sfs_pkg::*;
#(
  parameter int ROW_CYCLES   = ROW_OSC_CYCLES,
  parameter int WORD_CYCLES  = WORD_OSC_CYCLES,
  parameter int ERASE_CYCLES = ERASE_OSC_CYCLES
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  osc_pin_i,     // fast rc osc output
  input  wire logic [TUNE_W-1:0]     osc_tune_field_i,
  output logic                       arr_we_o,      // array word write
  output logic [ADDR_W-1:0]          arr_addr_o,
  output logic [INSN_W-1:0]          arr_data_o,
  output logic                       arr_erase_o,   // page erase strobe
  output logic [ADDR_W-1:0]          arr_page_o,
  output logic [TUNE_W-1:0]          tune_o,        // tune sampled at go
  sfs_if.dev                         bus
);
  localparam int ROWS_PER_PG = PAGE_INSNS / ROW_INSNS;

  typedef enum logic [1:0] {
    SD_IDLE = 2'h0, SD_TIME = 2'h1, SD_COPY = 2'h3, SD_END = 2'h2
  } sfs_dst_t;

  typedef struct packed {
    sfs_dst_t              st;
    logic [1:0]            key_st;   // 0 none, 1 first seen, 2 unlocked
    logic [1:0]            op;
    logic                  go;
    logic [ADDR_W-1:0]     row_base;
    logic [BUF_IDX_W-1:0]  word_idx;
    logic [BUF_IDX_W:0]    copy_idx;
    logic [OSC_CNT_W-1:0]  osc_cnt;
    logic [2:0]            osc_sync;  // two flops plus edge history
    logic                  tbl_ph;    // second cycle of a table write
    logic                  tbl_done;
    logic                  we;
    logic [ADDR_W-1:0]     waddr;
    logic [INSN_W-1:0]     wdata;
    logic                  erase;
    logic [TUNE_W-1:0]     tune;
  } sfs_ds_t;

  sfs_ds_t s_ff, nxt_s;
  logic [INSN_W-1:0] buf_mem [ROW_INSNS];
  logic [BUF_IDX_W-1:0] tbl_slot;
  logic osc_rise;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // instruction slot within its row: drops row bits
  function automatic logic [BUF_IDX_W-1:0] slot_of(
    input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = (a % ADDR_W'(ROW_BYTES)) / ADDR_W'(INSN_BYTES);
    return r[BUF_IDX_W-1:0];
  endfunction

  // align down to a boundary
  function automatic logic [ADDR_W-1:0] align(
    input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a - (a % b);
  endfunction

  assign tbl_slot = slot_of(bus.tbl_addr);
  assign osc_rise = s_ff.osc_sync[1] & ~s_ff.osc_sync[2];

  // ----------------------------------------------------------------------
  // holding buffer write, low and high halves
  // ----------------------------------------------------------------------
  // only the buffer is written, never the array
  always_ff @(posedge clk_sys_i) begin
    if (bus.tbl_wr && s_ff.st == SD_IDLE) begin
      if (bus.tbl_hi)
        buf_mem[tbl_slot][INSN_W-1:LOW_W] <= bus.tbl_data[HIGH_W-1:0];
      else
        buf_mem[tbl_slot][LOW_W-1:0] <= bus.tbl_data;
    end
  end

  // ----------------------------------------------------------------------
  // control and sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.osc_sync = {s_ff.osc_sync[1:0], osc_pin_i};
    nxt_s.tbl_done = 1'b0;
    nxt_s.we       = 1'b0;
    nxt_s.erase    = 1'b0;
    // two-cycle table write handshake
    if (bus.tbl_wr && s_ff.st == SD_IDLE) begin
      nxt_s.tbl_ph   = 1'b1;
      nxt_s.row_base = align(bus.tbl_addr, ADDR_W'(ROW_BYTES));
      nxt_s.word_idx = tbl_slot;
    end
    if (s_ff.tbl_ph) begin
      nxt_s.tbl_ph   = 1'b0;
      nxt_s.tbl_done = 1'b1;
    end
    // unlock key tracking: a table write, a wrong key or a control write while idle breaks the sequence
    if (bus.key_wr) begin
      if (bus.key_data == KEY_FIRST)
        nxt_s.key_st = 2'h1;
      else if (bus.key_data == KEY_SECOND && s_ff.key_st == 2'h1)
        nxt_s.key_st = 2'h2;
      else
        nxt_s.key_st = 2'h0;
    end else if (bus.tbl_wr) begin
      nxt_s.key_st = 2'h0;
    end
    unique case (s_ff.st)
      SD_IDLE: begin
        // operation select and start in one write
        if (bus.ctrl_wr) begin
          nxt_s.key_st = 2'h0;
          nxt_s.op     = bus.ctrl_data[CTRL_OP_LSB +: CTRL_OP_W];
          if (bus.ctrl_data[CTRL_GO_BIT] && s_ff.key_st == 2'h2 &&
              bus.ctrl_data[CTRL_OP_LSB +: CTRL_OP_W] != SFS_OP_NONE)
          begin
            nxt_s.go      = 1'b1;
            nxt_s.osc_cnt = '0;
            nxt_s.tune    = osc_tune_field_i;
            nxt_s.st      = SD_TIME;
          end                                           // else
        end
      end
      SD_TIME: begin
        if (osc_rise) begin
          nxt_s.osc_cnt = s_ff.osc_cnt + 1'b1;
          if ((s_ff.op == SFS_OP_ROW &&
               s_ff.osc_cnt == OSC_CNT_W'(ROW_CYCLES - 1)) ||
              (s_ff.op == SFS_OP_WORD &&
               s_ff.osc_cnt == OSC_CNT_W'(WORD_CYCLES - 1)) ||
              (s_ff.op == SFS_OP_ERASE &&
               s_ff.osc_cnt == OSC_CNT_W'(ERASE_CYCLES - 1))) begin
            nxt_s.copy_idx = '0;
            nxt_s.st       = SD_COPY;
          end
        end
      end
      SD_COPY: begin
        unique case (s_ff.op)
          SFS_OP_ERASE: begin
            nxt_s.erase = 1'b1;
            nxt_s.waddr = align(s_ff.row_base, ADDR_W'(PAGE_BYTES));
            nxt_s.st    = SD_END;
          end
          SFS_OP_WORD: begin
            nxt_s.we    = 1'b1;
            nxt_s.waddr = s_ff.row_base +
                          ADDR_W'(s_ff.word_idx) * ADDR_W'(INSN_BYTES);
            nxt_s.wdata = buf_mem[s_ff.word_idx];
            nxt_s.st    = SD_END;
          end
          default: begin                                // row
            nxt_s.we       = 1'b1;
            nxt_s.waddr    = s_ff.row_base + ADDR_W'(s_ff.copy_idx) *
                             ADDR_W'(INSN_BYTES);
            nxt_s.wdata    = buf_mem[s_ff.copy_idx[BUF_IDX_W-1:0]];
            nxt_s.copy_idx = s_ff.copy_idx + 1'b1;
            if (s_ff.copy_idx == 7'(ROW_INSNS - 1))
              nxt_s.st = SD_END;
          end
        endcase
      end
      SD_END: begin
        nxt_s.go = 1'b0;                                // self clear
        nxt_s.st = SD_IDLE;
      end
      default: nxt_s.st = SD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // stall spans the whole job so the core cannot fetch mid-program
  assign bus.stall    = s_ff.go;
  assign bus.ctrl_rd  = {s_ff.go, 13'h0000, s_ff.op};
  assign bus.tbl_done = s_ff.tbl_done;
  assign arr_we_o     = s_ff.we;
  assign arr_addr_o   = s_ff.waddr;
  assign arr_data_o   = s_ff.wdata;
  assign arr_erase_o  = s_ff.erase;
  assign arr_page_o   = s_ff.waddr;
  assign tune_o       = s_ff.tune;
endmodule
`default_nettype wire

// [verification/sfs_props.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// checks on the core-to-sequencer link
// ----------------------------------------------------------------------
module sfs_props
  import sfs_pkg::*;
#(
  parameter int STALL_MAX = 400
)(
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  input  wire logic              tbl_wr,
  input  wire logic              tbl_hi,
  input  wire logic [ADDR_W-1:0] tbl_addr,
  input  wire logic [LOW_W-1:0]  tbl_data,
  input  wire logic              key_wr,
  input  wire logic [7:0]        key_data,
  input  wire logic              ctrl_wr,
  input  wire logic [15:0]       ctrl_data,
  input  wire logic [15:0]       ctrl_rd,
  input  wire logic              stall,
  input  wire logic              tbl_done
);
  default clocking dcb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  logic              key1_ff;    // first key was the last write
  logic              key2_ff;    // full key pair was the last write
  logic              lo_ok_ff;   // a low write was made in this job
  logic [ADDR_W-1:0] lo_addr_ff; // address of the latest low write
  logic [9:0]        run_ff;     // cycles spent stalled
  logic              go_ok;

  // any table or control write between the keys breaks the pair
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key1_ff    <= 1'b0;
      key2_ff    <= 1'b0;
      lo_ok_ff   <= 1'b0;
      lo_addr_ff <= '0;
      run_ff     <= 10'h000;
    end else begin
      key1_ff    <= key_wr ? (key_data == KEY_FIRST)
                           : key1_ff && !(tbl_wr || ctrl_wr);
      key2_ff    <= key_wr ? key1_ff && (key_data == KEY_SECOND)
                           : key2_ff && !(tbl_wr || ctrl_wr);
      lo_ok_ff   <= ctrl_wr ? 1'b0 : lo_ok_ff || (tbl_wr && !tbl_hi);
      lo_addr_ff <= (tbl_wr && !tbl_hi) ? tbl_addr : lo_addr_ff;
      run_ff     <= stall ? run_ff + 10'h001 : 10'h000;
    end
  end

  // a start counts only when keyed, idle and naming an operation
  assign go_ok = ctrl_wr && ctrl_data[CTRL_GO_BIT] && !stall && key2_ff
                 && (ctrl_data[1:0] != 2'h0);

  sequence go_s;
    go_ok;
  endsequence
  sequence busy_s;
    stall && ctrl_rd[CTRL_GO_BIT];
  endsequence

  go_start_a: assert property (go_s |=> busy_s)
    else $error("accepted start did not stall");
  go_refused_a: assert property (ctrl_wr && !stall && !key2_ff |=> !stall)
    else $error("unkeyed start was taken");
  stall_cause_a: assert property ($rose(stall) |-> $past(go_ok))
    else $error("stall without keyed start");
  busy_read_a: assert property (stall |-> ctrl_rd[CTRL_GO_BIT])
    else $error("go bit low while busy");
  go_clear_a: assert property ($fell(stall) |-> !ctrl_rd[CTRL_GO_BIT])
    else $error("go bit not cleared at end");
  stall_len_a: assert property (run_ff < STALL_MAX)
    else $error("stall too long");
  core_hold_a: assert property (stall |-> !tbl_wr)
    else $error("table write while stalled");
  tbl_done_a: assert property (tbl_wr && !stall |-> ##2 tbl_done)
    else $error("table write not done in two cycles");
  tbl_cause_a: assert property (tbl_done |-> $past(tbl_wr, 2))
    else $error("table done without write");
  key_order_a: assert property (key_wr && key_data == KEY_SECOND |-> key1_ff)
    else $error("second key without first");
  go_keyed_a: assert property (ctrl_wr && ctrl_data[CTRL_GO_BIT] |-> key2_ff)
    else $error("start issued without keys");
  hi_pair_a: assert property (tbl_wr && tbl_hi |-> tbl_addr == lo_addr_ff)
    else $error("high write not paired with low");
  fill_up_a: assert property (tbl_wr && !tbl_hi && lo_ok_ff |->
    tbl_addr > lo_addr_ff && tbl_addr / ROW_BYTES == lo_addr_ff / ROW_BYTES)
    else $error("buffer fill not ascending in one row");
endmodule
`default_nettype wire

// [verification/self_program_flash_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module self_program_flash_sequencer_tb;
  import sfs_pkg::*;
  localparam int OSC_N   = 4;  // short osc counts keep the run brief
  localparam int OSC_H   = 68; // half period, near 7.37 MHz
  localparam int MIN_RUN = (OSC_N - 1) * 2 * OSC_H / 50;
  logic              clk_sys_i = 1'b0;
  logic              resetn_i  = 1'b0;
  logic              osc_pin   = 1'b0;
  logic [TUNE_W-1:0] tune      = '0;
  logic              req       = 1'b0;
  logic [1:0]        req_op    = 2'h0;
  logic [ADDR_W-1:0] req_addr  = '0;
  logic [INSN_W-1:0] req_data  = '0;
  logic              busy, done, we_a, er_a, er_b, stall_seen;
  logic [ADDR_W-1:0] waddr_a, page_a, er_page;
  logic [INSN_W-1:0] wdata_a;
  logic [TUNE_W-1:0] tune_a;
  logic [15:0]       lfsr_q    = 16'h3ef1;
  int                err_total = 0;
  int                compares  = 0;
  int                er_n      = 0;
  int                er_b_n    = 0;
  logic [ADDR_W-1:0] wa_q[$];
  logic [INSN_W-1:0] wd_q[$];
  sfs_op_t           ops_t[8]  = '{SFS_OP_ROW, SFS_OP_ROW, SFS_OP_ROW,
    SFS_OP_WORD, SFS_OP_WORD, SFS_OP_ERASE, SFS_OP_ERASE, SFS_OP_ERASE};
  // zero marks a random address
  logic [ADDR_W-1:0] adr_t[8]  = '{24'h0000bf, 24'h0000c0, 24'h000000,
    24'h000000, 24'h0005fd, 24'h0005ff, 24'h000600, 24'h000000};

  sfs_if bus_a ();
  sfs_if bus_b ();  // second link, driven by the bench to break the rules

  sfs_core_end sfs_core_end_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .req_i(req), .req_op_i(req_op), .req_addr_i(req_addr),
    .req_data_i(req_data), .busy_o(busy), .done_o(done), .bus(bus_a));
  sfs_dev_end #(.ROW_CYCLES(OSC_N), .WORD_CYCLES(OSC_N),
    .ERASE_CYCLES(OSC_N)) sfs_dev_end_i (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .osc_pin_i(osc_pin), .osc_tune_field_i(tune),
    .arr_we_o(we_a), .arr_addr_o(waddr_a), .arr_data_o(wdata_a),
    .arr_erase_o(er_a), .arr_page_o(page_a), .tune_o(tune_a), .bus(bus_a));
  sfs_dev_end #(.ROW_CYCLES(OSC_N), .WORD_CYCLES(OSC_N),
    .ERASE_CYCLES(OSC_N)) sfs_dev_end_b_i (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .osc_pin_i(osc_pin), .osc_tune_field_i(tune),
    .arr_we_o(), .arr_addr_o(), .arr_data_o(), .arr_erase_o(er_b),
    .arr_page_o(), .tune_o(), .bus(bus_b));
  sfs_props sfs_props_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .tbl_wr(bus_a.tbl_wr), .tbl_hi(bus_a.tbl_hi), .tbl_addr(bus_a.tbl_addr),
    .tbl_data(bus_a.tbl_data), .key_wr(bus_a.key_wr),
    .key_data(bus_a.key_data), .ctrl_wr(bus_a.ctrl_wr),
    .ctrl_data(bus_a.ctrl_data), .ctrl_rd(bus_a.ctrl_rd),
    .stall(bus_a.stall), .tbl_done(bus_a.tbl_done));

  // osc runs free, unrelated in phase to the system clock
  always #25 clk_sys_i = ~clk_sys_i;
  always #OSC_H osc_pin = ~osc_pin;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] rnd24();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return {lfsr_q[7:0], lfsr_q ^ 16'h5a3c};
  endfunction
  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                              input int u);
    return ADDR_W'(a - a % u);
  endfunction
  task automatic cmp_word(input string what, input logic [23:0] exp,
                          input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // array activity seen by the bench; outputs are registered
  always @(posedge clk_sys_i) begin
    if (we_a === 1'b1) begin
      wa_q.push_back(waddr_a);
      wd_q.push_back(wdata_a);
    end
    if (er_a === 1'b1) begin
      er_n++;
      er_page = page_a;
    end
    if (er_b === 1'b1) er_b_n++;
    if (bus_a.stall === 1'b1) stall_seen = 1'b1;
  end

  // one job through the core end, then its array effects checked
  task automatic run_job(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                         input logic [INSN_W-1:0] pat);
    int n;
    logic [ADDR_W-1:0] r;
    logic [ADDR_W-1:0] base;
    r = rnd24();
    wa_q.delete();
    wd_q.delete();
    er_n = 0;
    stall_seen = 1'b0;
    @(posedge clk_sys_i);
    tune <= r[TUNE_W-1:0];
    req <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= pat;
    @(posedge clk_sys_i);
    req <= 1'b0;
    @(posedge clk_sys_i);
    cmp_flag("busy", 1'b1, busy);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
    end
    base = (op == SFS_OP_ROW) ? align(a, ROW_BYTES) : a;
    cmp_flag("done", 1'b1, done);
    cmp_flag("busy end", 1'b0, busy);
    cmp_word("writes", (op == SFS_OP_ROW) ? 24'h000040 :
      (op == SFS_OP_WORD) ? 24'h000001 : 24'h000000, 24'(wa_q.size()));
    foreach (wa_q[i]) begin
      cmp_word("array addr", ADDR_W'(base + INSN_BYTES * i), wa_q[i]);
      cmp_word("array data", pat, wd_q[i]);
    end
    cmp_word("erases", (op == SFS_OP_ERASE) ? 24'h000001 : 24'h000000,
      24'(er_n));
    if (op == SFS_OP_ERASE) cmp_word("page", align(a, PAGE_BYTES), er_page);
    cmp_word("tune", 24'(r[TUNE_W-1:0]), 24'(tune_a));
    cmp_flag("stalled", 1'b1, stall_seen);
  endtask

  // one write on the second link: 0 key, 1 control, 2 table
  task automatic b_wr(input int kind, input logic [15:0] d);
    @(posedge clk_sys_i);
    bus_b.key_wr <= (kind == 0);
    bus_b.ctrl_wr <= (kind == 1);
    bus_b.tbl_wr <= (kind == 2);
    bus_b.key_data <= d[7:0];
    bus_b.ctrl_data <= d;
    bus_b.tbl_data <= d;
    @(posedge clk_sys_i);
    bus_b.key_wr <= 1'b0;
    bus_b.ctrl_wr <= 1'b0;
    bus_b.tbl_wr <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    logic [ADDR_W-1:0] a;
    {bus_b.tbl_wr, bus_b.key_wr, bus_b.ctrl_wr, bus_b.tbl_hi} = 4'h0;
    bus_b.tbl_addr = '0;
    bus_b.tbl_data = '0;
    bus_b.key_data = '0;
    bus_b.ctrl_data = '0;
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      a = (adr_t[k] == '0) ? align(rnd24() & 24'h01ffff, INSN_BYTES) : adr_t[k];
      run_job(ops_t[k], a, rnd24());
      $display("test job %0d done", k);
    end
    // refused starts: no keys, broken pair, wrong order, no operation
    b_wr(1, 16'h8003);
    b_wr(0, 16'h0055);
    b_wr(2, 16'h1234);
    b_wr(0, 16'h00aa);
    b_wr(1, 16'h8003);
    b_wr(0, 16'h00aa);
    b_wr(0, 16'h0055);
    b_wr(1, 16'h8003);
    b_wr(0, 16'h0055);
    b_wr(0, 16'h00aa);
    b_wr(1, 16'h8000);
    repeat (2) @(posedge clk_sys_i);
    cmp_flag("b stall", 1'b0, bus_b.stall);
    cmp_word("b erases", 24'h000000, 24'(er_b_n));
    b_wr(0, 16'h0055);
    b_wr(0, 16'h00aa);
    b_wr(1, 16'h8003);
    #1;
    cmp_flag("b busy read", 1'b1, bus_b.ctrl_rd[CTRL_GO_BIT]);
    n = 0;
    while (bus_b.stall === 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    cmp_flag("b go cleared", 1'b0, bus_b.ctrl_rd[CTRL_GO_BIT]);
    cmp_flag("b run length", 1'b1, n >= MIN_RUN);
    cmp_word("b erases", 24'h000001, 24'(er_b_n));
    // keys are spent: a second start must be refused
    b_wr(1, 16'h8003);
    repeat (2) @(posedge clk_sys_i);
    cmp_flag("b reuse", 1'b0, bus_b.stall);
    $display("test second link done");
    report_and_stop();
  end

  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
